// *** wmi_pkg.sv ***
// Constants, register map and types of the winding mode and input logic block
// Operation
// - Speed search from a terminal is taken only while the motor coasts.
// - Calibration indication is shown for as long as a speed search runs.
// - Winding drives a triangular frequency around the base frequency.
// - Winding starts after run turns on, only with enable select 1 or 2.
// - Winding first accelerates with the first accel time to the set frequency.
// - Operation select 1 or 3: base rises with length, second frequency at stop length.
// - Operation select 2 or 3: random rise ratio, off when maximum is below minimum.
// - Operation select 3 combines length-driven base and random rise ratio.
// - Terminal with function 13 ends winding and holds the present frequency.
// - Stop during winding decelerates to zero with the first decel time.
// - Trial, tuning, timer and PID take precedence and block winding start.
// - Terminal 1 function 14 counts pulses; length is count times ratio over 1000.
// - Winding length is readable as a monitor item.
// - Terminal 3 function 14 clears the accumulated winding length.
// - Polarity bit 0 senses normally open, 1 senses inverted.
// - Terminals one to five sit on polarity bits 0 to 4; bits 5 to 15 unused.
// - Direction and run inputs are always normally open.
// - A three-wire stop terminal always senses normally closed.
// - Jog frequency accepts 0.5 to 400.0 Hz with own accel and decel times.
// - Jog times cover 0.04 s as code 0 and 0.1 to 3600 s.
// - External run source and jog switch on give jog-ready; pins then run it.
// - Under vector control jog frequency is limited to 1 to 120 Hz.
package wmi_pkg;
  localparam int CLK_HZ = 50000000;
  // Ramp timing: a time code in 0.1 s spans the full 400 Hz scale
  localparam int TIME_UNIT_MS = 100;
  localparam int FULL_SCALE_STEPS = 4000;
  localparam int JOG_MIN_TIME_US = 40000;
  localparam logic [25:0] STEP_CYC = 26'(CLK_HZ / 1000 * TIME_UNIT_MS / FULL_SCALE_STEPS);
  localparam logic [25:0] MIN_STEP_CYC = 26'(CLK_HZ / 1000000 * JOG_MIN_TIME_US / FULL_SCALE_STEPS);
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_POL = 8'h04;
  localparam logic [7:0] OFF_FSEL = 8'h08;
  localparam logic [7:0] OFF_SETF = 8'h0C;
  localparam logic [7:0] OFF_SECF = 8'h10;
  localparam logic [7:0] OFF_STOPLEN = 8'h14;
  localparam logic [7:0] OFF_RATIO = 8'h18;
  localparam logic [7:0] OFF_LENRATIO = 8'h1C;
  localparam logic [7:0] OFF_ACCDEC = 8'h20;
  localparam logic [7:0] OFF_JOGF = 8'h24;
  localparam logic [7:0] OFF_JOGT = 8'h28;
  localparam logic [7:0] OFF_TRAV = 8'h2C;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_LENMON = 8'h34;
  // Field positions of the control register
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_OP_LSB = 2;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_VEC_BIT = 7;
  localparam int POL_BITS = 5;
  // Terminal function codes
  localparam logic [3:0] FN_JOG = 4'h3;
  localparam logic [3:0] FN_3WIRE = 4'hA;
  localparam logic [3:0] FN_FREEZE = 4'hD;
  localparam logic [3:0] FN_LENGTH = 4'hE;
  localparam logic [3:0] FN_SEARCH = 4'hF;
  localparam logic [2:0] SRC_EXT_MIN = 3'h2;
  localparam logic [2:0] SRC_EXT_MAX = 3'h5;
  // Frequencies in 0.1 Hz, times in 0.1 s
  localparam logic [15:0] JOG_F_MIN = 16'h0005;
  localparam logic [15:0] JOG_F_MAX = 16'h0FA0;
  localparam logic [15:0] VEC_F_MIN = 16'h000A;
  localparam logic [15:0] VEC_F_MAX = 16'h04B0;
  localparam logic [15:0] JOG_T_MAX = 16'h8CA0;
  localparam logic [15:0] JOG_T_COARSE = 16'h2710;
  localparam logic [15:0] JOG_T_COARSE_STEP = 16'h000A;
  localparam logic [31:0] LEN_DIV = 32'h0000_03E8;
  localparam logic [7:0] RATIO_FULL = 8'h64;
  localparam logic [7:0] RATIO_DEFAULT = 8'h32;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // Values after reset
  localparam logic [15:0] RST_SETF = 16'h01F4;
  localparam logic [15:0] RST_JOGF = 16'h0064;
  localparam logic [15:0] RST_TIME = 16'h0032;
  localparam logic [15:0] RST_LENRATIO = 16'h03E8;
  localparam logic [15:0] RST_PACE = 16'h0010;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_RUN = 7'b0000010,
    ST_TRAV = 7'b0000100,
    ST_HOLD = 7'b0001000,
    ST_DECEL = 7'b0010000,
    ST_JOG = 7'b0100000,
    ST_SEARCH = 7'b1000000
  } wmi_state_t;

  // Terminal pins: five switches, run/stop and direction
  typedef struct packed {
    logic [4:0] sw;
    logic run;
    logic dir;
  } wmi_pins_t;

  typedef struct packed {
    wmi_pins_t s1;
    wmi_pins_t s2;
    wmi_pins_t s3;
    wmi_pins_t lvl;
  } wmi_sync_t;

  typedef struct packed {
    logic [15:0] q;
    logic [7:0] rnd;
  } wmi_lfsr_t;
endpackage

// *** wmi_sync.sv ***
// Three-stage pin synchroniser that accepts a change when stages two and three agree
module wmi_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire wmi_pkg::wmi_pins_t pins,
  output wmi_pkg::wmi_pins_t clean
);
  import wmi_pkg::*;

  wmi_sync_t s;
  wmi_sync_t next_s;

  // Stage one feeds only stage two; the held level moves once two and three agree
  always_comb begin
    next_s = s;
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.lvl = (s.s2 & s.s3) | (s.lvl & (s.s2 | s.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign clean = s.lvl;
endmodule

// *** wmi_lfsr.sv ***
// Pseudo-random byte source for the rise ratio, advanced on request
module wmi_lfsr (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  output logic [7:0] rnd
);
  import wmi_pkg::*;

  wmi_lfsr_t s;
  wmi_lfsr_t next_s;

  // Galois form, taps 16,14,13,11; output byte refreshed on each step
  always_comb begin
    next_s = s;
    if (step) begin
      next_s.q = {1'b0, s.q[15:1]} ^ (s.q[0] ? 16'hB400 : 16'h0000);
      next_s.rnd = s.q[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{q: LFSR_SEED, rnd: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  assign rnd = s.rnd;
endmodule

// *** wmi_top.sv ***
// Winding traverse, length counter, input polarity and jog control with APB registers
module wmi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wmi_pkg::wmi_pins_t pins,
  input wire logic motor_coasting,
  input wire logic [3:0] other_func_active,
  input wire logic search_done,
  input wire logic [15:0] search_freq,
  output logic [15:0] freq_cmd,
  output logic dir_cmd,
  output logic speed_search_req,
  output logic calib_show,
  output logic jog_ready,
  output logic [15:0] winding_length_monitor
);
  import wmi_pkg::*;

  typedef struct packed {
    logic [1:0] en_sel;
    logic [1:0] op_sel;
    logic [2:0] cmd_src;
    logic vector;
    logic [4:0] pol;
    logic [19:0] fsel;
    logic [15:0] set_f;
    logic [15:0] sec_f;
    logic [15:0] stop_len;
    logic [7:0] rmax;
    logic [7:0] rmin;
    logic [15:0] len_ratio;
    logic [15:0] acc_t;
    logic [15:0] dec_t;
    logic [15:0] jog_f;
    logic [15:0] jog_acc;
    logic [15:0] jog_dec;
    logic [15:0] amp;
    logic [15:0] pace;
    wmi_state_t st;
    logic jog_stop;
    logic [15:0] freq;
    logic [16:0] tri_pos;
    logic up;
    logic [7:0] ratio;
    logic [25:0] tick;
    logic [15:0] count;
    logic [15:0] length;
    logic t1_prev;
    logic jog_rdy;
    logic [31:0] prdata;
  } wmi_top_t;

  wmi_top_t s;
  wmi_top_t next_s;
  wmi_pins_t clean;
  logic [7:0] rnd;
  logic rnd_step;
  logic [4:0] act;
  logic [3:0] fn [5];
  logic wr;
  logic rd_setup;
  logic hit;
  logic [31:0] rd_val;
  logic ext_src;
  logic wind_en;
  logic busy;
  logic freeze;
  logic search_ok;
  logic jog_sw;
  logic run;
  logic [15:0] jog_lim;
  logic [15:0] base;
  logic signed [16:0] diff;
  logic signed [33:0] prod;
  logic signed [33:0] quo;
  logic [31:0] len_full;
  logic [8:0] span;
  logic [16:0] rnd_scaled;
  logic [25:0] lim;
  logic [15:0] t_sel;
  logic step_now;
  logic [15:0] tgt;
  logic [15:0] wave;
  logic [23:0] tpace;

  wmi_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins(pins),
    .clean(clean)
  );

  wmi_lfsr u_lfsr (
    .pclk(pclk),
    .presetn(presetn),
    .step(rnd_step),
    .rnd(rnd)
  );

  // Polarity-corrected terminal activity
  always_comb begin
    for (int i = 0; i < POL_BITS; i++) begin
      fn[i] = s.fsel[4*i +: 4];
      if (fn[i] == FN_3WIRE) begin
        act[i] = ~clean.sw[i];
      end else begin
        act[i] = s.pol[i] ? ~clean.sw[i] : clean.sw[i];
      end
    end
  end

  // Terminal functions and mode conditions
  always_comb begin
    run = clean.run;
    ext_src = (s.cmd_src >= SRC_EXT_MIN) && (s.cmd_src <= SRC_EXT_MAX);
    wind_en = (s.en_sel == 2'h1) || (s.en_sel == 2'h2);
    busy = |other_func_active;
    freeze = 1'b0;
    search_ok = 1'b0;
    jog_sw = 1'b0;
    for (int i = 0; i < POL_BITS; i++) begin
      freeze = freeze | (act[i] && fn[i] == FN_FREEZE);
      search_ok = search_ok | (act[i] && fn[i] == FN_SEARCH);
      jog_sw = jog_sw | (act[i] && fn[i] == FN_JOG);
    end
    search_ok = search_ok & motor_coasting;
  end

  // Jog frequency limit under vector control
  always_comb begin
    jog_lim = s.jog_f;
    if (s.vector && s.jog_f < VEC_F_MIN) begin
      jog_lim = VEC_F_MIN;
    end else if (s.vector && s.jog_f > VEC_F_MAX) begin
      jog_lim = VEC_F_MAX;
    end
  end

  // Base frequency follows length from set to second frequency
  always_comb begin
    diff = $signed({1'b0, s.sec_f}) - $signed({1'b0, s.set_f});
    prod = 34'(diff * $signed({1'b0, s.length}));
    quo = (s.stop_len == 16'h0000) ? 34'sd0 : prod / $signed({18'h00000, s.stop_len});
    base = s.set_f;
    if (s.op_sel[0]) begin
      if (s.length >= s.stop_len) begin
        base = s.sec_f;
      end else begin
        base = s.set_f + quo[15:0];
      end
    end
    len_full = s.count * {16'h0000, s.len_ratio};
    wave = 16'(base + s.tri_pos[15:0] - s.amp);
    if ({1'b0, base} + s.tri_pos < {1'b0, s.amp}) begin
      wave = 16'h0000; // Never below standstill near the bottom of the wave
    end
  end

  // Random rise ratio within the allowed span
  always_comb begin
    span = {1'b0, s.rmax} - {1'b0, s.rmin} + 9'h001;
    rnd_scaled = rnd * span;
    tpace = s.up ? s.ratio * s.pace : (RATIO_FULL - s.ratio) * s.pace;
  end

  // Ramp pace: time code in 0.1 s, code zero is the short minimum
  always_comb begin
    case (s.st)
      ST_DECEL: t_sel = s.jog_stop ? s.jog_dec : s.dec_t;
      ST_JOG: t_sel = s.jog_acc;
      default: t_sel = s.acc_t;
    endcase
    if (s.st == ST_TRAV) begin
      lim = {2'b00, tpace};
    end else if (t_sel == 16'h0000) begin
      lim = MIN_STEP_CYC;
    end else begin
      lim = 26'(t_sel * STEP_CYC);
    end
    step_now = (s.tick + 26'h0000001) >= lim;
  end

  // APB decode: writes take effect in access, read data captured in setup
  always_comb begin
    wr = psel && penable && pwrite;
    rd_setup = psel && !penable;
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: rd_val = {24'h000000, s.vector, s.cmd_src, s.op_sel, s.en_sel};
      OFF_POL: rd_val = {27'h0000000, s.pol};
      OFF_FSEL: rd_val = {12'h000, s.fsel};
      OFF_SETF: rd_val = {16'h0000, s.set_f};
      OFF_SECF: rd_val = {16'h0000, s.sec_f};
      OFF_STOPLEN: rd_val = {16'h0000, s.stop_len};
      OFF_RATIO: rd_val = {16'h0000, s.rmin, s.rmax};
      OFF_LENRATIO: rd_val = {16'h0000, s.len_ratio};
      OFF_ACCDEC: rd_val = {s.dec_t, s.acc_t};
      OFF_JOGF: rd_val = {16'h0000, s.jog_f};
      OFF_JOGT: rd_val = {s.jog_dec, s.jog_acc};
      OFF_TRAV: rd_val = {s.pace, s.amp};
      OFF_STATUS: rd_val = {s.freq, 1'b0, s.st, s.jog_rdy, act, clean.run, clean.dir};
      OFF_LENMON: rd_val = {16'h0000, s.length};
      default: hit = 1'b0;
    endcase
  end

  // Clamp a jog time to its range and coarse step
  function automatic logic [15:0] jog_time(input logic [15:0] v);
    logic [15:0] r;
    r = (v > JOG_T_MAX) ? JOG_T_MAX : v;
    if (r >= JOG_T_COARSE) begin
      r = r - (r % JOG_T_COARSE_STEP);
    end
    return r;
  endfunction

  // Move one step toward a target
  function automatic logic [15:0] ramp(input logic [15:0] f, input logic [15:0] t);
    if (f < t) begin
      return f + 16'h0001;
    end else if (f > t) begin
      return f - 16'h0001;
    end
    return f;
  endfunction

  // Next state of registers, counter and run sequence
  always_comb begin
    next_s = s;
    rnd_step = 1'b0;
    tgt = s.freq;
    if (rd_setup) begin
      next_s.prdata = rd_val;
    end
    if (wr) begin
      case (paddr)
        OFF_CTRL: begin
          next_s.en_sel = pwdata[CTRL_EN_LSB +: 2];
          next_s.op_sel = pwdata[CTRL_OP_LSB +: 2];
          next_s.cmd_src = pwdata[CTRL_SRC_LSB +: 3];
          next_s.vector = pwdata[CTRL_VEC_BIT];
        end
        OFF_POL: next_s.pol = pwdata[POL_BITS-1:0];
        OFF_FSEL: next_s.fsel = pwdata[19:0];
        OFF_SETF: next_s.set_f = pwdata[15:0];
        OFF_SECF: next_s.sec_f = pwdata[15:0];
        OFF_STOPLEN: next_s.stop_len = pwdata[15:0];
        OFF_RATIO: begin
          next_s.rmax = pwdata[7:0];
          next_s.rmin = pwdata[15:8];
        end
        OFF_LENRATIO: next_s.len_ratio = pwdata[15:0];
        OFF_ACCDEC: begin
          next_s.acc_t = pwdata[15:0];
          next_s.dec_t = pwdata[31:16];
        end
        OFF_JOGF: begin
          if (pwdata[15:0] < JOG_F_MIN) begin
            next_s.jog_f = JOG_F_MIN;
          end else if (pwdata[15:0] > JOG_F_MAX) begin
            next_s.jog_f = JOG_F_MAX;
          end else begin
            next_s.jog_f = pwdata[15:0];
          end
        end
        OFF_JOGT: begin
          next_s.jog_acc = jog_time(pwdata[15:0]);
          next_s.jog_dec = jog_time(pwdata[31:16]);
        end
        OFF_TRAV: begin
          next_s.amp = pwdata[15:0];
          next_s.pace = pwdata[31:16];
        end
        default: ;
      endcase
    end
    // Pulse edges on terminal one; a clear and an edge together leave one count
    next_s.t1_prev = act[0];
    if (wind_en && fn[2] == FN_LENGTH && act[2]) begin
      next_s.count = 16'h0000;
    end
    if (wind_en && fn[0] == FN_LENGTH && act[0] && !s.t1_prev) begin
      next_s.count = (next_s.count == 16'h0000) ? 16'h0001 : s.count + 16'h0001;
    end
    next_s.length = 16'(len_full / LEN_DIV);
    next_s.jog_rdy = ext_src && jog_sw;
    next_s.tick = step_now ? 26'h0000000 : s.tick + 26'h0000001;
    case (s.st)
      ST_IDLE: begin
        next_s.freq = 16'h0000;
        next_s.jog_stop = 1'b0;
        if (run && s.jog_rdy) begin
          next_s.st = ST_JOG;
        end else if (run) begin
          next_s.st = ST_RUN;
        end
      end
      ST_RUN: begin
        tgt = s.set_f;
        if (!run) begin
          next_s.st = ST_DECEL;
        end else if (wind_en && !busy && s.freq == s.set_f) begin
          next_s.st = ST_TRAV;
          next_s.tri_pos = {1'b0, s.amp};
          next_s.up = 1'b1;
          next_s.ratio = RATIO_DEFAULT;
        end
      end
      ST_TRAV: begin
        next_s.freq = wave;
        if (!run) begin
          next_s.st = ST_DECEL;
        end else if (freeze) begin
          next_s.st = ST_HOLD;
        end else if (busy || !wind_en) begin
          next_s.st = ST_RUN;
        end else if (step_now) begin
          if (s.up && s.tri_pos >= {s.amp, 1'b0}) begin
            next_s.up = 1'b0;
          end else if (!s.up && s.tri_pos == 17'h00000) begin
            next_s.up = 1'b1;
            rnd_step = 1'b1;
            next_s.ratio = RATIO_DEFAULT;
            if (s.op_sel[1] && s.rmax >= s.rmin) begin
              next_s.ratio = s.rmin + rnd_scaled[15:8];
            end
          end else begin
            next_s.tri_pos = s.up ? s.tri_pos + 17'h00001 : s.tri_pos - 17'h00001;
          end
        end
      end
      ST_HOLD: begin
        if (!run) begin
          next_s.st = ST_DECEL;
        end
      end
      ST_DECEL: begin
        tgt = 16'h0000;
        if (run && !s.jog_stop) begin
          next_s.st = ST_RUN;
        end else if (s.freq == 16'h0000) begin
          next_s.st = ST_IDLE;
        end
      end
      ST_JOG: begin
        tgt = jog_lim;
        if (!run) begin
          next_s.st = ST_DECEL;
          next_s.jog_stop = 1'b1;
        end
      end
      ST_SEARCH: begin
        if (search_done) begin
          next_s.freq = search_freq;
          next_s.st = run ? ST_RUN : ST_DECEL;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    if ((s.st == ST_RUN || s.st == ST_DECEL || s.st == ST_JOG) && step_now) begin
      next_s.freq = ramp(s.freq, tgt);
    end
    if (search_ok && s.st != ST_SEARCH) begin
      next_s.st = ST_SEARCH;
    end
  end

  // Single register stage for the whole block state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.set_f <= RST_SETF;
      s.jog_f <= RST_JOGF;
      s.acc_t <= RST_TIME;
      s.dec_t <= RST_TIME;
      s.jog_acc <= RST_TIME;
      s.jog_dec <= RST_TIME;
      s.len_ratio <= RST_LENRATIO;
      s.pace <= RST_PACE;
      s.ratio <= RATIO_DEFAULT;
    end else begin
      s <= next_s;
    end
  end

  // Outputs; the bus answers at once, unmapped offsets flag an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = s.prdata;
  assign freq_cmd = s.freq;
  assign dir_cmd = clean.dir;
  assign speed_search_req = (s.st == ST_SEARCH);
  assign calib_show = (s.st == ST_SEARCH);
  assign jog_ready = s.jog_rdy;
  assign winding_length_monitor = s.length;
endmodule

// *** wmi_asserts.sv ***
// Port-level assertions for the winding and input block
module wmi_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire wmi_pkg::wmi_pins_t pins,
  input wire logic motor_coasting,
  input wire logic [15:0] search_freq,
  input wire logic [15:0] freq_cmd,
  input wire logic dir_cmd,
  input wire logic speed_search_req,
  input wire logic calib_show,
  input wire logic jog_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import wmi_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // No wait states on the register bus
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  // Error exactly on unmapped or misaligned words
  property p_err_map;
    psel && penable |-> pslverr == !(paddr <= OFF_LENMON && paddr[1:0] == 2'h0);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_err_only; pslverr |-> psel && penable; endproperty
  a_err_only: assert property (p_err_only) else $error("pslverr outside access");
  // Read data must not move after the access edge
  property p_rd_hold; psel && penable |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("prdata moved after access");
  // Search only starts from a coasting motor
  property p_search_in; $rose(speed_search_req) |-> $past(motor_coasting); endproperty
  a_search_in: assert property (p_search_in) else $error("search while driven");
  property p_search_load; $fell(speed_search_req) |-> freq_cmd == $past(search_freq); endproperty
  a_search_load: assert property (p_search_load) else $error("resume freq wrong");
  property p_calib; calib_show == speed_search_req; endproperty
  a_calib: assert property (p_calib) else $error("calibration display mismatch");
  // Direction ignores polarity; eight quiet cycles cover the filter
  property p_dir; $stable(pins.dir) [*8] |-> dir_cmd == pins.dir; endproperty
  a_dir: assert property (p_dir) else $error("direction not normally open");
  c_err: cover property (psel && penable && pslverr);
  c_search: cover property ($rose(speed_search_req));
  c_jog: cover property ($rose(jog_ready));
endmodule

bind wmi_top wmi_asserts u_wmi_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
  .motor_coasting(motor_coasting), .search_freq(search_freq), .freq_cmd(freq_cmd),
  .dir_cmd(dir_cmd), .speed_search_req(speed_search_req), .calib_show(calib_show),
  .jog_ready(jog_ready)
);

// *** wmi_pins_model.sv ***
// Switch contacts, run and direction inputs and pulse source on the terminals
module wmi_pins_model (
  input wire logic pclk,
  output wmi_pkg::wmi_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import wmi_pkg::*;
  initial pins = '0;
  // Run and direction come from outside, changed just after an edge
  task automatic set(input logic [4:0] sw, input logic run, input logic dir);
    pins <= '{sw: sw, run: run, dir: dir};
  endtask
  // Pulses wide enough to pass the agreement filter
  task automatic pulse(input int n);
    repeat (n) begin
      pins.sw[0] <= 1'b1;
      repeat (6) @(posedge pclk);
      pins.sw[0] <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask
endmodule

// *** tb_wmi_top.sv ***
// Register and terminal tests of the winding block
module tb_wmi_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wmi_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic motor_coasting = 1'b0;
  logic [3:0] other_func_active = 4'h0;
  logic search_done = 1'b0;
  logic [15:0] search_freq = 16'h0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, dir_cmd, speed_search_req, calib_show, jog_ready;
  logic [15:0] freq_cmd, wlen;
  logic [35:0] obs;
  wmi_pins_t pins;
  int err_count = 0;
  int n_tests = 0;
  // Clamped writes and their read-back
  logic [7:0] t_a [6] = '{OFF_JOGF, OFF_JOGF, OFF_JOGF, OFF_JOGT, OFF_JOGT, OFF_JOGT};
  logic [31:0] t_w [6] = '{32'h0, 32'hFFFF, 32'h4D2, 32'h0, 32'h2715_270F, 32'hFFFF};
  logic [31:0] t_e [6] = '{32'h5, 32'hFA0, 32'h4D2, 32'h0, 32'h2710_270F, 32'h8CA0};

  wmi_top u_wmi_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .motor_coasting(motor_coasting), .other_func_active(other_func_active),
    .search_done(search_done), .search_freq(search_freq), .freq_cmd(freq_cmd),
    .dir_cmd(dir_cmd), .speed_search_req(speed_search_req), .calib_show(calib_show),
    .jog_ready(jog_ready), .winding_length_monitor(wlen)
  );
  wmi_pins_model u_wmi_pins_model (.pclk(pclk), .pins(pins));

  initial forever #10 pclk = ~pclk;
  // Outputs are looked at mid-cycle, away from the edge race
  always @(negedge pclk) obs <= {freq_cmd, wlen, dir_cmd, speed_search_req, calib_show, jog_ready};

  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then an idle cycle so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk(32'(i >= 50), 32'h0);
    if (i >= 50) end_of_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wait_freq(input logic [15:0] f);
    int i;
    for (i = 0; i < 8000 && obs[35:20] !== f; i++) @(posedge pclk);
    chk(32'(i >= 8000), 32'h0);
    if (i >= 8000) end_of_test();
  endtask

  initial begin
    cyc(8);
    presetn <= 1'b1;
    cyc(1);
    rdc(OFF_SETF, 32'h1F4);
    rdc(OFF_LENRATIO, 32'h3E8);
    wr(OFF_POL, 32'hFFFF_FFFF);
    rdc(OFF_POL, 32'h1F);
    rdc(8'h38, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    for (int k = 0; k < 6; k++) begin
      wr(t_a[k], t_w[k]);
      rdc(t_a[k], t_e[k]);
    end
    // Polarity, three-wire stop and fixed direction sensing
    wr(OFF_POL, 32'h0);
    wr(OFF_FSEL, 32'hA00);
    u_wmi_pins_model.set(5'h01, 1'b0, 1'b1);
    cyc(8);
    rdc(OFF_STATUS, 32'h115);
    wr(OFF_POL, 32'h3);
    cyc(4);
    rdc(OFF_STATUS, 32'h119);
    chk({31'h0, obs[3]}, 32'h1);
    // Length counting, monitor and clear
    wr(OFF_POL, 32'h0);
    wr(OFF_FSEL, 32'hE0E);
    wr(OFF_LENRATIO, 32'h7D0);
    wr(OFF_CTRL, 32'h1);
    u_wmi_pins_model.set(5'h00, 1'b0, 1'b0);
    cyc(8);
    u_wmi_pins_model.pulse(3);
    cyc(4);
    rdc(OFF_LENMON, 32'h6);
    chk({16'h0, obs[19:4]}, 32'h6);
    u_wmi_pins_model.set(5'h04, 1'b0, 1'b0);
    cyc(8);
    rdc(OFF_LENMON, 32'h0);
    // Ramp, precedence, traverse, freeze and stop
    wr(OFF_FSEL, 32'h0);
    wr(OFF_ACCDEC, 32'h0001_0001);
    wr(OFF_SETF, 32'h3);
    wr(OFF_TRAV, 32'h0010_0000);
    other_func_active <= 4'h1;
    u_wmi_pins_model.set(5'h00, 1'b1, 1'b0);
    wait_freq(16'h3);
    cyc(4);
    rdc(OFF_STATUS, 32'h0003_0202);
    other_func_active <= 4'h0;
    cyc(4);
    rdc(OFF_STATUS, 32'h0003_0402);
    // Two-point base: zero stop length selects the second frequency at once
    wr(OFF_SECF, 32'h5);
    wr(OFF_CTRL, 32'h5);
    rdc(OFF_STATUS, 32'h0005_0402);
    // Combined mode at zero length sits on the set frequency again
    wr(OFF_STOPLEN, 32'h2);
    wr(OFF_CTRL, 32'hD);
    rdc(OFF_STATUS, 32'h0003_0402);
    wr(OFF_FSEL, 32'hD0);
    u_wmi_pins_model.set(5'h02, 1'b1, 1'b0);
    cyc(8);
    rdc(OFF_STATUS, 32'h0003_080A);
    u_wmi_pins_model.set(5'h00, 1'b0, 1'b0);
    wait_freq(16'h0);
    cyc(2);
    rdc(OFF_STATUS, 32'h100);
    // Jog ready needs an external run source
    wr(OFF_FSEL, 32'h3);
    wr(OFF_CTRL, 32'h20);
    u_wmi_pins_model.set(5'h01, 1'b0, 1'b0);
    cyc(8);
    chk({31'h0, obs[0]}, 32'h1);
    // Jog run under vector control: a 0.5 Hz setting is lifted to 1 Hz
    wr(OFF_JOGF, 32'h5);
    wr(OFF_JOGT, 32'h0);
    wr(OFF_CTRL, 32'hA0);
    u_wmi_pins_model.set(5'h01, 1'b1, 1'b0);
    wait_freq(16'hA);
    cyc(600);
    chk({16'h0, obs[35:20]}, 32'hA);
    u_wmi_pins_model.set(5'h01, 1'b0, 1'b0);
    wait_freq(16'h0);
    rdc(OFF_STATUS, 32'h184);
    wr(OFF_CTRL, 32'h0);
    cyc(2);
    chk({31'h0, obs[0]}, 32'h0);
    // Speed search ignored until the motor coasts
    wr(OFF_FSEL, 32'hF);
    cyc(4);
    chk({31'h0, obs[2]}, 32'h0);
    motor_coasting <= 1'b1;
    cyc(3);
    chk({31'h0, obs[1]}, 32'h1);
    search_freq <= 16'h0002;
    search_done <= 1'b1;
    cyc(1);
    search_done <= 1'b0;
    motor_coasting <= 1'b0;
    cyc(1);
    chk({16'h0, obs[35:20]}, 32'h2);
    end_of_test();
  end
endmodule
